// ==== logic/csr_params.svh ====
// Constants for the clock select and rate control block
//
// Overview of operation
// - Three reference inputs, one active at once
// - Four outputs, each off, 1x, 8x or 32x
// - Optional 255/238 or 238/255 ratio scaling
// - Manual or automatic input selection regimes
// - Automatic switching revertive or non-revertive
// - Per-input signal-loss alarms, frequency-offset alarms on the two main inputs
// - Digital loop filter drives oscillator control word
// - Bandwidth code 11/00/01/10 gives 6400/3200/1600/800
// - Rate code 11/10/01/00 gives 32x/8x/1x/off
// - Exactly four selectable loop bandwidths
// - Revertive mode returns to preferred input
// - Manual mode uses two-bit manual input choice
// - Scaling code decode with frame sync enable
// - Main inputs compared against third reference
`ifndef CSR_PARAMS_SVH
`define CSR_PARAMS_SVH

// ----------------------------------------
// Counts and widths
// ----------------------------------------
`define CSR_N_IN 3
`define CSR_N_OUT 4
`define CSR_ERR_W 16
`define CSR_CW_W 24
`define CSR_CW_RST 24'h800000
`define CSR_STABLE_CNT 4'h3
`define CSR_LOS_CNT 4'h4

// ----------------------------------------
// Register offsets, reset values and control fields
// ----------------------------------------
`define CSR_A_CTRL 8'h00
`define CSR_A_RATE 8'h04
`define CSR_A_STAT 8'h08
`define CSR_A_CW 8'h0C
`define CSR_CTRL_RST 12'h000
`define CSR_RATE_RST 8'h55
`define CSR_F_BW 1:0
`define CSR_F_FEC 3:2
`define CSR_F_MAN 5:4
`define CSR_F_AUTO 6
`define CSR_F_REVERT 7
`define CSR_F_PREF 9:8
`define CSR_F_SMC 10
`define CSR_F_FOS_OFF 11

// ----------------------------------------
// Loop bandwidth in Hz
// ----------------------------------------
`define CSR_BW_6400 16'h1900
`define CSR_BW_3200 16'h0C80
`define CSR_BW_1600 16'h0640
`define CSR_BW_800 16'h0320

// ----------------------------------------
// Multiplier and scaling factors
// ----------------------------------------
`define CSR_MUL_1 6'h01
`define CSR_MUL_8 6'h08
`define CSR_MUL_32 6'h20
`define CSR_FEC_N 8'hFF
`define CSR_FEC_D 8'hEE
`define CSR_FOS_THR_SMC 16'h0190
`define CSR_FOS_THR_S3 16'h0040

`endif

// ==== logic/csr_pkg.sv ====
// Types for the clock select and rate control block
package csr_pkg;
   typedef enum logic [1:0] {
      CSR_BW_6400_E = 2'h3,
      CSR_BW_3200_E = 2'h0,
      CSR_BW_1600_E = 2'h1,
      CSR_BW_800_E = 2'h2
   } csr_bw_e;

   typedef enum logic [1:0] {
      CSR_RATE_OFF = 2'h0,
      CSR_RATE_1X = 2'h1,
      CSR_RATE_8X = 2'h2,
      CSR_RATE_32X = 2'h3
   } csr_rate_e;

   typedef enum logic [2:0] {
      CSR_ST_A = 3'h1,
      CSR_ST_B = 3'h2,
      CSR_ST_F = 3'h4
   } csr_sel_e;

   typedef struct packed {
      logic [5:0] mult;
      logic en;
   } csr_out_cfg_s;

   typedef struct packed {
      logic [7:0] num;
      logic [7:0] den;
      logic frame_sync_en;
   } csr_scale_s;

   typedef struct packed {
      logic freq_offset_alarm;
      logic signal_loss_alarm;
   } csr_alarm_s;
endpackage

// ==== logic/csr_sync_filter.sv ====
// Select-input stabiliser: holds a value until it stays steady
`timescale 1ns/1ps
`include "csr_params.svh"
module csr_sync_filter #(
   parameter int W = 2
) (
   input wire logic mclk, // Clock
   input wire logic rst_n, // Synchronous reset, active low
   input wire logic [W-1:0] din, // Raw select value
   output logic [W-1:0] dout // Stable select value
);
   logic [W-1:0] samp_r, samp_nxt;
   logic [W-1:0] out_r, out_nxt;
   logic [3:0] cnt_r, cnt_nxt;

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   // Accept only steady value
   always_comb begin
      samp_nxt = din;
      out_nxt = out_r;
      cnt_nxt = cnt_r;
      if (din != samp_r) begin
         cnt_nxt = 4'h0;
      end else if (cnt_r != `CSR_STABLE_CNT) begin
         cnt_nxt = cnt_r + 4'h1;
      end else begin
         out_nxt = samp_r;
      end
   end

   // Registers
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         samp_r <= '0;
         out_r <= '0;
         cnt_r <= 4'h0;
      end else begin
         samp_r <= samp_nxt;
         out_r <= out_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   assign dout = out_r;
endmodule

// ==== logic/csr_loop_filter.sv ====
// Digital proportional-integral loop filter for the oscillator
`timescale 1ns/1ps
`include "csr_params.svh"
module csr_loop_filter (
   input wire logic mclk, // Clock
   input wire logic rst_n, // Synchronous reset, active low
   input wire logic err_valid, // Phase error sample strobe
   input wire logic signed [`CSR_ERR_W-1:0] phase_err, // Phase detector error term
   input wire logic [1:0] gain_shift, // Gain from bandwidth code
   input wire logic hold, // Freeze the control word
   output logic [`CSR_CW_W-1:0] ctrl_word // Oscillator control word
);
   logic signed [`CSR_CW_W-1:0] integ_r, integ_nxt;
   logic [`CSR_CW_W-1:0] cw_r, cw_nxt;
   logic signed [`CSR_CW_W-1:0] err_x;
   logic signed [`CSR_CW_W-1:0] prop;

   // ----------------------------------------
   // Filter arithmetic
   // ----------------------------------------
   // Error term to control word
   always_comb begin
      err_x = `CSR_CW_W'(phase_err);
      prop = err_x <<< (3'h4 + {1'b0, gain_shift});
      integ_nxt = integ_r;
      cw_nxt = cw_r;
      if (err_valid && !hold) begin
         integ_nxt = integ_r + (err_x <<< {1'b0, gain_shift});
         cw_nxt = `CSR_CW_RST + integ_nxt + prop;
      end
   end

   // Registers
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         integ_r <= '0;
         cw_r <= `CSR_CW_RST;
      end else begin
         integ_r <= integ_nxt;
         cw_r <= cw_nxt;
      end
   end

   assign ctrl_word = cw_r;
endmodule

// ==== logic/csr_top.sv ====
// Clock select, alarm and rate decode top with APB registers
//
// Implementation choices: register access over APB and the address map.
`timescale 1ns/1ps
`include "csr_params.svh"
module csr_top (
   input wire logic mclk, // Clock, 250 MHz
   input wire logic rst_n, // Synchronous reset, active low
   input wire logic psel, // APB select
   input wire logic penable, // APB enable
   input wire logic pwrite, // APB direction
   input wire logic [7:0] paddr, // APB byte address
   input wire logic [31:0] pwdata, // APB write data
   output logic [31:0] prdata, // APB read data
   output logic pready, // APB ready
   output logic pslverr, // APB error
   input wire logic [2:0] in_activity, // Input edge seen this cycle, per input
   input wire logic [15:0] offset_a, // Measured offset of input A vs third
   input wire logic [15:0] offset_b, // Measured offset of input B vs third
   input wire logic err_valid, // Phase error strobe
   input wire logic [15:0] phase_err, // Phase detector error
   output logic [1:0] active_input, // Active input index, 0..2
   output logic [23:0] ctrl_word, // Oscillator control word
   output logic [15:0] loop_bw_hz, // Decoded loop bandwidth
   output logic [23:0] out_cfg, // Per-output multiplier, zero when off
   output logic [16:0] scale_cfg, // Scaling numerator, denominator, sync
   output logic frame_sync_out, // Frame sync enable
   output logic [2:0] freq_offset_alarm, // Offset alarm per main input; bit 2 stays zero
   output logic [2:0] signal_loss_alarm // Loss alarm per input
);
   // ----------------------------------------
   // Register map (byte offsets)
   // ----------------------------------------
   localparam logic [7:0] A_CTRL = `CSR_A_CTRL;
   localparam logic [7:0] A_RATE = `CSR_A_RATE;
   localparam logic [7:0] A_STAT = `CSR_A_STAT;
   localparam logic [7:0] A_CW = `CSR_A_CW;

   // Control: [1:0] bw, [3:2] scaling, [5:4] manual choice, [6] auto,
   // [7] revertive, [9:8] preferred, [10] fos threshold SMC, [11] fos off
   logic [11:0] ctrl_r, ctrl_nxt;
   // Rate: two bits per output, output 0 in [1:0]
   logic [7:0] rate_r, rate_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic [2:0] los_r, los_nxt;
   logic [2:0] fos_r, fos_nxt;
   logic [3:0] los_cnt_r [3];
   logic [3:0] los_cnt_nxt [3];
   csr_pkg::csr_sel_e sel_r, sel_nxt;
   logic [1:0] bw_s, fec_s, man_s;
   logic [7:0] rate_s;
   logic [2:0] bad;
   logic wr_en, rd_en;
   logic [15:0] thr;
   csr_pkg::csr_scale_s scl;

   // Index to one-hot state
   function automatic csr_pkg::csr_sel_e idx2st(input logic [1:0] i);
      case (i)
         2'h1: idx2st = csr_pkg::CSR_ST_B;
         2'h2: idx2st = csr_pkg::CSR_ST_F;
         default: idx2st = csr_pkg::CSR_ST_A;
      endcase
   endfunction

   // Code 3 names the third input, like code 2
   function automatic logic [1:0] clip_idx(input logic [1:0] i);
      clip_idx = (i == 2'h3) ? 2'h2 : i;
   endfunction

   // Rate code to output configuration
   function automatic csr_pkg::csr_out_cfg_s rate_dec(input logic [1:0] c);
      case (c)
         2'h3: rate_dec = '{mult: `CSR_MUL_32, en: 1'b1};
         2'h2: rate_dec = '{mult: `CSR_MUL_8, en: 1'b1};
         2'h1: rate_dec = '{mult: `CSR_MUL_1, en: 1'b1};
         default: rate_dec = '{mult: 6'h00, en: 1'b0};
      endcase
   endfunction

   // ----------------------------------------
   // Select stabilisers
   // ----------------------------------------
   // Filter the manual, scaling, bandwidth and rate fields
   // One shared filter: nothing moves until the whole set has been steady,
   // so a half-written control word never reaches the decoders
   csr_sync_filter #(.W(14)) u_sync_ctl (
      .mclk(mclk),
      .rst_n(rst_n),
      .din({ctrl_r[`CSR_F_MAN], ctrl_r[`CSR_F_FEC], ctrl_r[`CSR_F_BW], rate_r}),
      .dout({man_s, fec_s, bw_s, rate_s})
   );

   // ----------------------------------------
   // APB slave, zero wait states
   // ----------------------------------------
   // Never stalls and never flags an error
   assign pready = 1'b1;
   assign pslverr = 1'b0;
   // Writes land at the access edge; reads are captured in the setup
   // cycle, so prdata already stands during the access cycle
   assign wr_en = psel && penable && pwrite;
   assign rd_en = psel && !penable && !pwrite;

   // Register write and read decode
   always_comb begin
      ctrl_nxt = ctrl_r;
      rate_nxt = rate_r;
      rdata_nxt = rdata_r;
      if (wr_en) begin
         if (paddr == A_CTRL) begin
            ctrl_nxt = pwdata[11:0];
         end else if (paddr == A_RATE) begin
            rate_nxt = pwdata[7:0];
         end
      end
      if (rd_en) begin
         if (paddr == A_CTRL) begin
            rdata_nxt = {20'h00000, ctrl_r};
         end else if (paddr == A_RATE) begin
            rdata_nxt = {24'h000000, rate_r};
         end else if (paddr == A_STAT) begin
            // Offset alarms, loss alarms, one-hot selection
            rdata_nxt = {24'h000000, fos_r[1:0], los_r, sel_r};
         end else if (paddr == A_CW) begin
            rdata_nxt = {8'h00, ctrl_word};
         end else begin
            rdata_nxt = 32'h00000000;
         end
      end
   end

   // Control, rate and read data registers
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         ctrl_r <= `CSR_CTRL_RST;
         rate_r <= `CSR_RATE_RST;
         rdata_r <= 32'h00000000;
      end else begin
         ctrl_r <= ctrl_nxt;
         rate_r <= rate_nxt;
         rdata_r <= rdata_nxt;
      end
   end
   assign prdata = rdata_r;

   // ----------------------------------------
   // Alarms
   // ----------------------------------------
   // Loss after five idle samples
   always_comb begin
      for (int i = 0; i < `CSR_N_IN; i++) begin
         los_cnt_nxt[i] = los_cnt_r[i];
         los_nxt[i] = los_r[i];
         // Any edge clears both the count and the alarm at once
         if (in_activity[i]) begin
            los_cnt_nxt[i] = 4'h0;
            los_nxt[i] = 1'b0;
         end else if (los_cnt_r[i] != `CSR_LOS_CNT) begin
            los_cnt_nxt[i] = los_cnt_r[i] + 4'h1;
         end else begin
            los_nxt[i] = 1'b1;
         end
      end
   end

   always_comb begin
      thr = ctrl_r[`CSR_F_SMC] ? `CSR_FOS_THR_SMC : `CSR_FOS_THR_S3;
      fos_nxt = 3'h0;
      // A silent third input leaves nothing to compare against
      if (!los_r[2] && !ctrl_r[`CSR_F_FOS_OFF]) begin
         fos_nxt[0] = offset_a > thr;
         fos_nxt[1] = offset_b > thr;
      end
   end

   // Alarm registers and idle counters
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         los_r <= 3'h0;
         fos_r <= 3'h0;
         for (int i = 0; i < `CSR_N_IN; i++) begin
            los_cnt_r[i] <= 4'h0;
         end
      end else begin
         los_r <= los_nxt;
         fos_r <= fos_nxt;
         for (int i = 0; i < `CSR_N_IN; i++) begin
            los_cnt_r[i] <= los_cnt_nxt[i];
         end
      end
   end
   // Alarm outputs; bad marks an input unfit for selection
   assign signal_loss_alarm = los_r;
   assign freq_offset_alarm = fos_r;
   assign bad = los_r | fos_r;

   // ----------------------------------------
   // Input selection state machine
   // ----------------------------------------
   // Manual or automatic choice
   always_comb begin
      sel_nxt = sel_r;
      if (!ctrl_r[`CSR_F_AUTO]) begin
         sel_nxt = idx2st(clip_idx(man_s));
      end else begin
         // Leave only an alarmed input; the other main input beats the third
         case (sel_r)
            csr_pkg::CSR_ST_A: begin
               if (bad[0]) begin
                  sel_nxt = !bad[1] ? csr_pkg::CSR_ST_B : csr_pkg::CSR_ST_F;
               end
            end
            csr_pkg::CSR_ST_B: begin
               if (bad[1]) begin
                  sel_nxt = !bad[0] ? csr_pkg::CSR_ST_A : csr_pkg::CSR_ST_F;
               end
            end
            csr_pkg::CSR_ST_F: begin
               if (bad[2] && !bad[0]) begin
                  sel_nxt = csr_pkg::CSR_ST_A;
               end else if (bad[2] && !bad[1]) begin
                  sel_nxt = csr_pkg::CSR_ST_B;
               end
            end
            default: sel_nxt = csr_pkg::CSR_ST_A;
         endcase
         // Return once preferred is clean
         // Preferred input clean again: it overrides the choice above
         if (ctrl_r[`CSR_F_REVERT] && !bad[clip_idx(ctrl_r[`CSR_F_PREF])]) begin
            sel_nxt = idx2st(clip_idx(ctrl_r[`CSR_F_PREF]));
         end
      end
   end

   // Selection register, input A after reset
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         sel_r <= csr_pkg::CSR_ST_A;
      end else begin
         sel_r <= sel_nxt;
      end
   end

   // One active input at a time
   // Index form of the one-hot state
   assign active_input = sel_r == csr_pkg::CSR_ST_B ? 2'h1 :
                         sel_r == csr_pkg::CSR_ST_F ? 2'h2 : 2'h0;

   // ----------------------------------------
   // Bandwidth, rate and scaling decode
   // ----------------------------------------
   // Bandwidth code decode
   // Four bandwidth settings
   // Every code maps to one of the four bandwidths
   always_comb begin
      case (bw_s)
         2'h3: loop_bw_hz = `CSR_BW_6400;
         2'h0: loop_bw_hz = `CSR_BW_3200;
         2'h1: loop_bw_hz = `CSR_BW_1600;
         default: loop_bw_hz = `CSR_BW_800;
      endcase
   end

   // Four independent outputs
   // Output g uses rate bits [2g+1:2g]; a powered-down output shows zero
   genvar g;
   generate
      for (g = 0; g < `CSR_N_OUT; g++) begin : g_out
         csr_pkg::csr_out_cfg_s oc;
         assign oc = rate_dec(rate_s[g*2 +: 2]);
         assign out_cfg[g*6 +: 6] = oc.en ? oc.mult : 6'h00;
      end
   endgenerate

   // Scaling code decode
   // Only the 255/238 direction turns the frame sync off
   always_comb begin
      case (fec_s)
         2'h1: scl = '{num: `CSR_FEC_N, den: `CSR_FEC_D, frame_sync_en: 1'b0};
         2'h2: scl = '{num: `CSR_FEC_D, den: `CSR_FEC_N, frame_sync_en: 1'b1};
         default: scl = '{num: 8'h01, den: 8'h01, frame_sync_en: 1'b1};
      endcase
   end
   assign scale_cfg = scl;
   assign frame_sync_out = scl.frame_sync_en;

   // ----------------------------------------
   // Loop filter
   // ----------------------------------------
   // All inputs alarmed: hold the last control word
   csr_loop_filter u_lf (
      .mclk(mclk),
      .rst_n(rst_n),
      .err_valid(err_valid),
      .phase_err(phase_err),
      .gain_shift(bw_s),
      .hold(&bad),
      .ctrl_word(ctrl_word)
   );
endmodule

// ==== dv/csr_top_assertions.sv ====
// Checker for the clock select and rate control top
`timescale 1ns/1ps
module csr_top_assertions (
   input wire logic mclk, // Clock
   input wire logic rst_n, // Reset
   input wire logic [2:0] in_activity, // Edges
   input wire logic [15:0] offset_a, // Offset A
   input wire logic err_valid, // Error strobe
   input wire logic [1:0] active_input, // Active input
   input wire logic [23:0] ctrl_word, // Control word
   input wire logic [15:0] loop_bw_hz, // Bandwidth
   input wire logic [23:0] out_cfg, // Output rates
   input wire logic [16:0] scale_cfg, // Scaling
   input wire logic frame_sync_out, // Frame sync
   input wire logic [2:0] freq_offset_alarm, // Offset alarms
   input wire logic [2:0] signal_loss_alarm // Loss alarms
);
   // ------
   // Checks
   // ------
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   // Legal multiplier per output
   function automatic logic mul_ok(input logic [5:0] m);
      return m inside {6'h00, 6'h01, 6'h08, 6'h20};
   endfunction
   act_range_a: assert property (active_input != 2'h3)
      else $error("active input out of range");
   bw_set_a: assert property (
      loop_bw_hz inside {16'h1900, 16'h0C80, 16'h0640, 16'h0320})
      else $error("bandwidth not legal");
   rate_set_a: assert property (
      mul_ok(out_cfg[5:0]) && mul_ok(out_cfg[11:6]) && mul_ok(out_cfg[17:12])
      && mul_ok(out_cfg[23:18])) else $error("multiplier not legal");
   scale_pair_a: assert property (
      scale_cfg == 17'h1FFDC || scale_cfg == 17'h1DDFF
      || (scale_cfg[16:9] == scale_cfg[8:1] && scale_cfg[0])) else $error("bad scaling");
   sync_match_a: assert property (frame_sync_out == scale_cfg[0])
      else $error("frame sync differs from scaling");
   offs_main_a: assert property (!freq_offset_alarm[2])
      else $error("offset alarm on third input");
   offs_cause_a: assert property ($rose(freq_offset_alarm[0])
      |-> $past(offset_a) > 16'h0040 || $past(offset_a, 2) > 16'h0040)
      else $error("offset alarm without offset");
   loss_set_a: assert property (!in_activity[0] [*5]
      |-> ##[0:3] signal_loss_alarm[0]) else $error("loss alarm missing");
   loss_clear_a: assert property (in_activity[0] && signal_loss_alarm[0]
      |-> ##[1:3] !signal_loss_alarm[0]) else $error("loss alarm stuck");
   cw_hold_a: assert property (!err_valid [*3] |=> $stable(ctrl_word))
      else $error("control word moved without sample");
   // Main scenarios reached
   cover property ($rose(signal_loss_alarm[0]));
   cover property ($changed(active_input));
   cover property ($fell(frame_sync_out));
endmodule

// ==== dv/csr_ref_src.sv ====
// Model of the reference sources and phase detector
`timescale 1ns/1ps
module csr_ref_src (
   input wire logic mclk, // Clock
   input wire logic [2:0] alive, // Sources running
   input wire logic slow, // Edges every third cycle
   input wire logic pd_on, // Detector running
   output logic [2:0] in_activity, // Edge seen
   output logic err_valid, // Error strobe
   output logic [15:0] phase_err // Error term
);
   logic [1:0] ph = 2'h0;
   logic [2:0] div = 3'h0;
   logic [15:0] lfsr = 16'hACE1;
   // Source phase, sample divider and noise
   always @(posedge mclk) begin
      ph <= (slow && ph != 2'h2) ? ph + 2'h1 : 2'h0;
      div <= div + 3'h1;
      lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
   end
   assign in_activity = (ph == 2'h0) ? alive : 3'h0;
   assign err_valid = pd_on && div == 3'h0;
   // Term keeps changing between strobes
   assign phase_err = {{6{lfsr[9]}}, lfsr[9:0]};
endmodule

// ==== dv/tb_clock_select_rate_control.sv ====
// Self-checking bench for the clock select and rate control top
`timescale 1ns/1ps
module tb_clock_select_rate_control;
   // -------
   // Signals
   // -------
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic slow = 1'b0;
   logic pd_on = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata, rdat;
   logic pready, pslverr, err_valid, frame_sync_out;
   logic [2:0] in_activity, freq_offset_alarm, signal_loss_alarm;
   logic [2:0] alive = 3'h7;
   logic [15:0] offset_a = 16'h0000;
   logic [15:0] offset_b = 16'h0000;
   logic [15:0] phase_err, loop_bw_hz;
   logic [1:0] active_input;
   logic [23:0] ctrl_word, out_cfg;
   logic [16:0] scale_cfg;
   int exp_q[$];
   int err_count = 0;
   int comparisons = 0;
   int seed = 60;
   int c, pb, r;
   int model[2];
   int off_ctrl[5] = '{0, 32'h400, 32'h400, 0, 32'h800};
   logic [15:0] off_val[5] = '{16'h0040, 16'h0190, 16'h0191, 16'h0041, 16'h0041};
   logic off_exp[5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
   csr_top DUT (.mclk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .in_activity, .offset_a, .offset_b, .err_valid, .phase_err, .active_input,
      .ctrl_word, .loop_bw_hz, .out_cfg, .scale_cfg, .frame_sync_out, .freq_offset_alarm,
      .signal_loss_alarm);
   csr_ref_src u_src (.mclk, .alive, .slow, .pd_on, .in_activity, .err_valid, .phase_err);
   always #2 mclk = ~mclk;
   // -----
   // Tasks
   // -----
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         err_count++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic tmo();
      err_count++;
      $display("unexpected wait expected answer seen timeout");
      give_verdict();
   endtask
   // One APB transfer, read data left in rdat
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do begin
         @(posedge mclk);
         n++;
      end while (pready !== 1'b1 && n < 64);
      if (n >= 64)
         tmo();
      rdat = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic settle();
      repeat (12) @(posedge mclk);
      #1;
   endtask
   task automatic wait_act(input logic [1:0] e);
      int n;
      n = 0;
      #1;
      while (active_input !== e && n < 60) begin
         @(posedge mclk);
         #1;
         n++;
      end
      if (n >= 60)
         tmo();
   endtask
   function automatic logic [15:0] exp_bw(input int k);
      case (k)
         3: return 16'h1900;
         0: return 16'h0C80;
         1: return 16'h0640;
         default: return 16'h0320;
      endcase
   endfunction
   function automatic logic [5:0] exp_mul(input int k);
      case (k)
         3: return 6'h20;
         2: return 6'h08;
         1: return 6'h01;
         default: return 6'h00;
      endcase
   endfunction
   // --------
   // Sequence
   // --------
   initial begin
      repeat (5) @(posedge mclk);
      rst_n <= 1'b1;
      apb(1'b0, 8'h00, 0);
      chk("ctrl_rst", 0, rdat);
      apb(1'b0, 8'h04, 0);
      chk("rate_rst", 32'h55, rdat);
      apb(1'b0, 8'h0C, 0);
      chk("cw_rst", 32'h800000, rdat);
      apb(1'b1, 8'h10, 32'hFFFFFFFF);
      apb(1'b0, 8'h10, 0);
      chk("unmapped", 0, rdat);
      chk("slverr", 0, pslverr);
      chk("act_rst", 0, active_input);
      pd_on <= 1'b1;
      $display("end of reset test");
      pb = 0;
      for (int i = 0; i < 4; i++) begin
         c = i ^ 3;
         model[1] = $random(seed) & 32'hFF;
         model[0] = c | (c << 2);
         apb(1'b1, 8'h04, model[1]);
         apb(1'b1, 8'h00, model[0]);
         #1;
         chk("bw_early", exp_bw(pb), loop_bw_hz);
         settle();
         chk("bw", exp_bw(c), loop_bw_hz);
         for (int k = 0; k < 4; k++)
            exp_q.push_back(exp_mul(model[1] >> 2 * k & 3));
         for (int k = 0; k < 4; k++)
            chk("mult", exp_q.pop_front(), out_cfg[6 * k +: 6]);
         chk("frame_sync", c != 1, frame_sync_out);
         if (c == 1)
            chk("scale", 32'h1FFDC, scale_cfg);
         if (c == 2)
            chk("scale", 32'h1DDFF, scale_cfg);
         if (c == 3)
            chk("scale_rsv", 32'h203, scale_cfg);
         if (c == 0)
            chk("scale_unity", 32'h203, scale_cfg);
         apb(1'b0, 8'h00, 0);
         chk("ctrl_rd", model[0], rdat);
         pb = c;
      end
      $display("end of decode test");
      for (int m = 0; m < 4; m++) begin
         r = (m == 3) ? 2 : m;
         apb(1'b1, 8'h00, m << 4);
         settle();
         wait_act(2'(r));
         apb(1'b0, 8'h08, 0);
         chk("sel_status", 1 << r, rdat[2:0]);
      end
      $display("end of manual test");
      alive <= 3'h6;
      settle();
      chk("loss", 3'h1, signal_loss_alarm);
      apb(1'b0, 8'h08, 0);
      chk("loss_status", 3'h1, rdat[5:3]);
      alive <= 3'h7;
      slow <= 1'b1;
      settle();
      chk("loss_clr", 0, signal_loss_alarm);
      $display("end of loss test");
      for (int j = 0; j < 5; j++) begin
         apb(1'b1, 8'h00, off_ctrl[j]);
         offset_a <= off_val[j];
         offset_b <= off_val[j];
         settle();
         chk("offs", {1'b0, off_exp[j], off_exp[j]}, freq_offset_alarm);
      end
      @(posedge mclk) offset_a <= 16'h0000;
      offset_b <= 16'h0000;
      $display("end of offset test");
      apb(1'b1, 8'h00, 32'h40);
      wait_act(2'h0);
      @(posedge mclk) alive <= 3'h6;
      wait_act(2'h1);
      @(posedge mclk) alive <= 3'h7;
      settle();
      settle();
      chk("non_revert", 1, active_input);
      apb(1'b1, 8'h00, 32'hC0);
      wait_act(2'h0);
      @(posedge mclk) alive <= 3'h6;
      wait_act(2'h1);
      @(posedge mclk) alive <= 3'h7;
      wait_act(2'h0);
      apb(1'b1, 8'h00, 32'h1C0);
      wait_act(2'h1);
      @(posedge mclk) alive <= 3'h4;
      wait_act(2'h2);
      @(posedge mclk) alive <= 3'h7;
      wait_act(2'h1);
      chk("cw_move", 1, ctrl_word !== 24'h800000);
      $display("end of auto test");
      give_verdict();
   end
endmodule
bind csr_top csr_top_assertions u_chk (.mclk, .rst_n, .in_activity, .offset_a, .err_valid,
   .active_input, .ctrl_word, .loop_bw_hz, .out_cfg, .scale_cfg, .frame_sync_out,
   .freq_offset_alarm, .signal_loss_alarm);
